//--- inc/bfp_defines.svh
`ifndef BFP_DEFINES_SVH
`define BFP_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define BFP_ADDR_CTRL 12'h000
`define BFP_ADDR_STATUS 12'h004
`define BFP_ADDR_INT_STAT 12'h008
`define BFP_ADDR_INT_MASK 12'h00c
`define BFP_ADDR_DEADTIME 12'h010

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define BFP_CTRL_GAIN 0
`define BFP_CTRL_BBM 1
`define BFP_CTRL_RST 2'h2
`define BFP_INT_S2G 0
`define BFP_INT_UVLS 1
`define BFP_INT_UVCP 2
`define BFP_INT_RST 3'h0
`define BFP_DEAD_CYC_RST 8'h14
`define BFP_LATCH_RST 1'b1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BFP_CLK_MHZ 100
`define BFP_S2G_NOM_NS 500
`define BFP_S2G_NOM_UA 20
`define BFP_S2G_NOM_CYC ((`BFP_S2G_NOM_NS * `BFP_CLK_MHZ + 999) / 1000)

`endif

//--- inc/bfp_pkg.sv
package bfp_pkg;

    // State of one half-bridge
    typedef enum logic [1:0] {
        BFP_LEG_OFF,
        BFP_LEG_HS,
        BFP_LEG_LS
    } bfp_leg_t;

    typedef logic [2:0] bfp_phase_t;

endpackage

//--- hdl/bfp_sync.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------
module bfp_sync #(
    parameter int W = 1
) (
    input logic clk_sys,
    input logic resetn,
    input logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // Stage one feeds stage two only
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule

//--- hdl/bfp_top.sv
`timescale 1ns/10ps
`include "bfp_defines.svh"

module bfp_top #(
    parameter int CNT_W = 16,
    parameter int DEAD_W = 8
) (
    input logic clk_sys,
    input logic resetn,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input logic [2:0] pwm_hs,
    input logic [2:0] pwm_ls,
    input logic [2:0] phase_output_node,
    input logic [2:0] phase_sample_ctl,
    input logic uv_lowside,
    input logic uv_charge_pump,
    input logic fault_clear,
    input logic power_enable,
    input logic [7:0] short_check_delay_set,
    output logic [2:0] gate_hs,
    output logic [2:0] gate_ls,
    output logic [2:0] phase_hold,
    output logic amp_gain_high,
    output logic fault_n_out,
    output logic fault_n_oe_n,
    output logic irq
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    // Slowest delay (1 uA) needs 1000 cycles
    if (CNT_W < 10 || CNT_W > 32)
        $error("CNT_W must lie between 10 and 32");
    if (DEAD_W < 2 || DEAD_W > 32)
        $error("DEAD_W must lie between 2 and 32");

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [23:0] sync_out;
    bfp_pkg::bfp_phase_t hs_s, ls_s, node_s, sample_s;
    logic uv_ls_s, uv_cp_s, clr_s, en_s;
    logic [7:0] code_s;

    bfp_sync #(.W(24)) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .din({short_check_delay_set, power_enable, fault_clear,
              uv_charge_pump, uv_lowside, phase_sample_ctl,
              phase_output_node, pwm_ls, pwm_hs}),
        .dout(sync_out)
    );

    assign hs_s = sync_out[2:0];
    assign ls_s = sync_out[5:3];
    assign node_s = sync_out[8:6];
    assign sample_s = sync_out[11:9];
    assign uv_ls_s = sync_out[12];
    assign uv_cp_s = sync_out[13];
    assign clr_s = sync_out[14];
    assign en_s = sync_out[15];
    assign code_s = sync_out[23:16];

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [1:0] ctrl_q;
    logic [DEAD_W-1:0] dead_q;
    logic [2:0] int_stat_q, int_mask_q, int_evt;
    logic [31:0] prdata_q, rd_word;
    logic pready_q, pslverr_q, rd_hit, wr_en;
    logic fault_q, latch_q, irq_q;
    logic [CNT_W-1:0] limit_q;
    bfp_pkg::bfp_phase_t gate_hs_q, gate_ls_q, hold_q;

    assign wr_en = psel && penable && pready_q && pwrite;

    always_comb
    begin
        rd_word = 32'h0;
        rd_hit = 1'b1;
        case (paddr)
            `BFP_ADDR_CTRL: rd_word[1:0] = ctrl_q;
            `BFP_ADDR_STATUS: rd_word[14:0] = {gate_ls_q, 1'b0, gate_hs_q,
                2'h0, (limit_q == '0), en_s, uv_cp_s, uv_ls_s,
                latch_q, fault_q};
            `BFP_ADDR_INT_STAT: rd_word[2:0] = int_stat_q;
            `BFP_ADDR_INT_MASK: rd_word[2:0] = int_mask_q;
            `BFP_ADDR_DEADTIME: rd_word[DEAD_W-1:0] = dead_q;
            default: rd_hit = 1'b0;
        endcase
    end

    // No wait state: read data is captured in the setup cycle
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= psel && !penable;
            if (psel && !penable)
            begin
                prdata_q <= pwrite ? 32'h0 : rd_word;
                pslverr_q <= !rd_hit;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl_q <= `BFP_CTRL_RST;
            dead_q <= DEAD_W'(`BFP_DEAD_CYC_RST);
            int_mask_q <= `BFP_INT_RST;
        end
        else if (wr_en)
        begin
            if (paddr == `BFP_ADDR_CTRL)
                ctrl_q <= pwdata[1:0];
            if (paddr == `BFP_ADDR_INT_MASK)
                int_mask_q <= pwdata[2:0];
            if (paddr == `BFP_ADDR_DEADTIME)
                dead_q <= pwdata[DEAD_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Bridge legs with break-before-make
    // ------------------------------------------------------------
    bfp_pkg::bfp_leg_t leg_q [3];
    bfp_pkg::bfp_leg_t leg_d [3];
    bfp_pkg::bfp_leg_t want [3];
    logic [DEAD_W-1:0] idle_q [3];
    logic [DEAD_W-1:0] idle_d [3];
    logic [DEAD_W-1:0] need;

    // Conflicting requests turn the leg off rather than guess
    always_comb
    begin
        if (ctrl_q[`BFP_CTRL_BBM] && dead_q > DEAD_W'(1))
            need = dead_q;
        else
            need = DEAD_W'(1);
        for (int i = 0; i < 3; i++)
        begin
            if (!en_s || hs_s[i] == ls_s[i])
                want[i] = bfp_pkg::BFP_LEG_OFF;
            else if (hs_s[i])
                want[i] = bfp_pkg::BFP_LEG_HS;
            else
                want[i] = bfp_pkg::BFP_LEG_LS;
            idle_d[i] = DEAD_W'(1);
            case (leg_q[i])
                bfp_pkg::BFP_LEG_OFF:
                begin
                    if (want[i] != bfp_pkg::BFP_LEG_OFF && idle_q[i] >= need)
                        leg_d[i] = want[i];
                    else
                        leg_d[i] = bfp_pkg::BFP_LEG_OFF;
                    if (idle_q[i] != '1)
                        idle_d[i] = idle_q[i] + DEAD_W'(1);
                    else
                        idle_d[i] = idle_q[i];
                end
                bfp_pkg::BFP_LEG_HS, bfp_pkg::BFP_LEG_LS:
                begin
                    if (want[i] == leg_q[i])
                        leg_d[i] = leg_q[i];
                    else
                        leg_d[i] = bfp_pkg::BFP_LEG_OFF;
                end
                default: leg_d[i] = bfp_pkg::BFP_LEG_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < 3; i++)
            begin
                leg_q[i] <= bfp_pkg::BFP_LEG_OFF;
                idle_q[i] <= '0;
            end
            gate_hs_q <= 3'h0;
            gate_ls_q <= 3'h0;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                leg_q[i] <= leg_d[i];
                idle_q[i] <= idle_d[i];
                gate_hs_q[i] <= leg_d[i] == bfp_pkg::BFP_LEG_HS;
                gate_ls_q[i] <= leg_d[i] == bfp_pkg::BFP_LEG_LS;
            end
        end
    end

    // ------------------------------------------------------------
    // Short-to-ground check
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cnt_q [3];
    logic s2g_evt;

    // Delay scales with 1/current; code is the current in uA
    function automatic logic [CNT_W-1:0] s2g_limit(input logic [7:0] code);
        logic [31:0] num;
        num = 32'(`BFP_S2G_NOM_CYC * `BFP_S2G_NOM_UA);
        if (code == 8'h00)
            s2g_limit = '0;
        else
            s2g_limit = CNT_W'((num + 32'(code) - 32'h1) / 32'(code));
    endfunction

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            limit_q <= '0;
            for (int i = 0; i < 3; i++)
                cnt_q[i] <= '0;
        end
        else
        begin
            limit_q <= s2g_limit(code_s);
            for (int i = 0; i < 3; i++)
            begin
                if (!gate_hs_q[i])
                    cnt_q[i] <= '0;
                else if (cnt_q[i] < limit_q)
                    cnt_q[i] <= cnt_q[i] + CNT_W'(1);
            end
        end
    end

    // Node level is two cycles old after the synchroniser
    always_comb
    begin
        s2g_evt = 1'b0;
        for (int i = 0; i < 3; i++)
            if (gate_hs_q[i] && limit_q != '0 && !node_s[i] &&
                cnt_q[i] == limit_q - CNT_W'(1))
                s2g_evt = 1'b1;
    end

    // ------------------------------------------------------------
    // Error logic
    // ------------------------------------------------------------
    logic latch_d, fault_d, oe_n_q, uv_ls_p_q, uv_cp_p_q;

    always_comb
    begin
        if (s2g_evt)
            latch_d = 1'b1;
        else if (clr_s && !uv_ls_s && !uv_cp_s)
            latch_d = 1'b0;
        else
            latch_d = latch_q;
        fault_d = uv_ls_s || uv_cp_s || latch_d;
    end

    // Latch starts set so a startup fault needs an explicit clear
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            latch_q <= `BFP_LATCH_RST;
            fault_q <= 1'b1;
            oe_n_q <= 1'b0;
        end
        else
        begin
            latch_q <= latch_d;
            fault_q <= fault_d;
            oe_n_q <= !fault_d;
        end
    end

    // ------------------------------------------------------------
    // Sense amplifier control
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            hold_q <= 3'h7;
        else
            hold_q <= ~(gate_ls_q & sample_s);
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    assign int_evt = {uv_cp_s && !uv_cp_p_q, uv_ls_s && !uv_ls_p_q, s2g_evt};

    // New events win over a write-one-to-clear in the same cycle
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            int_stat_q <= `BFP_INT_RST;
            uv_ls_p_q <= 1'b0;
            uv_cp_p_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            uv_ls_p_q <= uv_ls_s;
            uv_cp_p_q <= uv_cp_s;
            if (wr_en && paddr == `BFP_ADDR_INT_STAT)
                int_stat_q <= (int_stat_q & ~pwdata[2:0]) | int_evt;
            else
                int_stat_q <= int_stat_q | int_evt;
            irq_q <= |(int_stat_q & int_mask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign gate_hs = gate_hs_q;
    assign gate_ls = gate_ls_q;
    assign phase_hold = hold_q;
    assign amp_gain_high = ctrl_q[`BFP_CTRL_GAIN];
    assign fault_n_out = 1'b0;
    assign fault_n_oe_n = oe_n_q;
    assign irq = irq_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_no_overlap: assert property (@(posedge clk_sys) disable iff (!resetn)
        (gate_hs_q & gate_ls_q) == 3'h0)
        else $error("both gates of a leg on");
    a_enable_off: assert property (@(posedge clk_sys) disable iff (!resetn)
        !en_s |=> gate_hs_q == 3'h0 && gate_ls_q == 3'h0)
        else $error("gates on while disabled");
    a_uv_fault: assert property (@(posedge clk_sys) disable iff (!resetn)
        (uv_ls_s || uv_cp_s) |=> !fault_n_oe_n && fault_q)
        else $error("undervoltage not driving fault pin");
    a_s2g_latch: assert property (@(posedge clk_sys) disable iff (!resetn)
        s2g_evt |=> latch_q && !fault_n_oe_n)
        else $error("short event did not latch");
    a_latch_holds: assert property (@(posedge clk_sys) disable iff (!resetn)
        latch_q && !clr_s |=> latch_q)
        else $error("latch dropped without clear");
    a_clear_works: assert property (@(posedge clk_sys) disable iff (!resetn)
        clr_s && !uv_ls_s && !uv_cp_s && !s2g_evt |=> !latch_q)
        else $error("clear did not reset latch");
    a_clear_prio: assert property (@(posedge clk_sys) disable iff (!resetn)
        clr_s && uv_ls_s |=> fault_q && !fault_n_oe_n)
        else $error("clear overrode active fault");
    a_delay_nom: assert property (@(posedge clk_sys) disable iff (!resetn)
        code_s == 8'h14 |=> limit_q == CNT_W'(`BFP_S2G_NOM_CYC))
        else $error("nominal check delay wrong");
    a_delay_slow: assert property (@(posedge clk_sys) disable iff (!resetn)
        code_s == 8'h0a |=> limit_q == CNT_W'(2 * `BFP_S2G_NOM_CYC))
        else $error("delay not inverse to current");
    a_open_pin: assert property (@(posedge clk_sys) disable iff (!resetn)
        code_s == 8'h00 |=> ##1 !s2g_evt)
        else $error("short check fired with open pin");
    a_dead_gap: assert property (@(posedge clk_sys) disable iff (!resetn)
        $fell(gate_hs_q[0]) && ctrl_q[`BFP_CTRL_BBM] && dead_q >= 3
        |-> !gate_ls_q[0] [*3])
        else $error("dead time too short");
    a_hold_on: assert property (@(posedge clk_sys) disable iff (!resetn)
        !sample_s[1] |=> phase_hold[1] ##1 1'b1)
        else $error("sample low did not hold");
    a_irq_level: assert property (@(posedge clk_sys) disable iff (!resetn)
        s2g_evt && int_mask_q[`BFP_INT_S2G] |=> ##1 irq)
        else $error("masked-in short did not raise irq");

endmodule

//--- verification/bfp_mcu_model.sv
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Controller at the far side of the bridge pins
// ----------------------------------------------------------------
module bfp_mcu_model (
    input logic clk_sys,
    input logic resetn,
    input logic fault_n_oe_n,
    input logic en_req,
    input logic clr_req,
    input logic [2:0] hold_req,
    output logic power_enable,
    output logic fault_clear,
    output logic [2:0] phase_sample_ctl
);
    logic [2:0] boot_q;

    // Enable goes through a resistor, so the open-drain fault pin wins
    assign power_enable = en_req & fault_n_oe_n;
    // Sampling left free unless a hold point is wanted
    assign phase_sample_ctl = ~hold_req;
    // Four-cycle clear pulse after reset drops the start-up fault
    assign fault_clear = clr_req | (boot_q != 3'h0 && boot_q != 3'h5);

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            boot_q <= 3'h0;
        else if (boot_q != 3'h5)
            boot_q <= boot_q + 3'h1;
    end
endmodule

//--- verification/bfp_top_tb.sv
`timescale 1ns/10ps

module bfp_top_tb;
    logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, seed = 32'hb291;
    logic [2:0] pwm_hs = 0, pwm_ls = 0, node = 3'h7, hold_req = 0;
    logic uv_ls = 0, uv_cp = 0, en_req = 1, clr_req = 0, err;
    logic [7:0] code = 8'h14;
    wire [31:0] prdata;
    wire pready, pslverr, fault_clear, power_enable, gain, fault_n_oe_n, irq;
    wire [2:0] sample_ctl, gate_hs, gate_ls, phase_hold;
    wire fault_n_out;
    int fail_count = 0, checks = 0, n, k, dt, lim;
    int exp_q[int];
    logic [1:0] ct;

    bfp_top bfp_top_i (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwm_hs(pwm_hs),
        .pwm_ls(pwm_ls), .phase_output_node(node),
        .phase_sample_ctl(sample_ctl), .uv_lowside(uv_ls),
        .uv_charge_pump(uv_cp), .fault_clear(fault_clear),
        .power_enable(power_enable), .short_check_delay_set(code),
        .gate_hs(gate_hs), .gate_ls(gate_ls), .phase_hold(phase_hold),
        .amp_gain_high(gain), .fault_n_out(fault_n_out),
        .fault_n_oe_n(fault_n_oe_n), .irq(irq));

    bfp_mcu_model bfp_mcu_model_i (.clk_sys(clk_sys), .resetn(resetn),
        .fault_n_oe_n(fault_n_oe_n), .en_req(en_req), .clr_req(clr_req),
        .hold_req(hold_req), .power_enable(power_enable),
        .fault_clear(fault_clear), .phase_sample_ctl(sample_ctl));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task complete_run;
        if (fail_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task cyc(input int c);
        repeat (c) @(posedge clk_sys);
    endtask

    // No fixed wait state assumed: poll pready under a bound
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1;
        t = 0;
        do
        begin
            @(posedge clk_sys);
            t++;
        end while (pready !== 1'b1 && t < 20);
        chk(t < 20, 1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk_sys);
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d);
        exp_q[a] = d;
    endtask

    task wait_gate;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end while (gate_hs[0] !== 1'b1 && n < 50);
        chk(gate_hs[0], 1);
    endtask

    always @(posedge clk_sys)
        if (resetn)
            chk(gate_hs & gate_ls, 0);

    initial
    begin
        forever #5 clk_sys = ~clk_sys;
    end

    initial
    begin
        #200000;
        fail_count++;
        complete_run;
    end

    initial
    begin
        cyc(2);
        resetn <= 1;
        cyc(1);
        // Latch comes out of reset set until the boot clear reaches it
        chk(fault_n_oe_n, 0);
        chk(fault_n_out, 0);
        chk({phase_hold, irq}, 4'he);
        exp_q[12'h000] = 2;
        exp_q[12'h00c] = 0;
        exp_q[12'h010] = 32'h14;
        foreach (exp_q[a])
        begin
            apb(0, a[11:0], 0);
            chk(rd, exp_q[a]);
        end
        apb(0, 12'h020, 0);
        chk({err, rd}, {1'b1, 32'h0});
        apb(1, 12'h008, 7);
        cyc(6);
        chk(fault_n_oe_n, 1);
        for (int i = 0; i < 3; i++)
        begin
            dt = (i == 2) ? 1 : 2 + xs() % 8;
            ct = (i == 1) ? 2'h0 : 2'h3;
            wr(12'h000, ct);
            wr(12'h010, dt);
            apb(0, 12'h010, 0);
            chk(rd, exp_q[12'h010]);
            chk(gain, ct[0]);
            pwm_hs <= 3'h1;
            wait_gate;
            pwm_hs <= 0;
            pwm_ls <= 3'h1;
            n = 0;
            k = 0;
            do
            begin
                @(posedge clk_sys);
                k++;
                if (gate_hs[0] === 1'b0 && gate_ls[0] === 1'b0)
                    n++;
            end while (gate_ls[0] !== 1'b1 && k < 100);
            chk(n, (ct[1] && dt > 1) ? dt : 1);
            // Hold follows the low-side gate one edge later
            cyc(1);
            chk(phase_hold[0], 0);
            hold_req <= 3'h1;
            cyc(5);
            chk(phase_hold[0], 1);
            hold_req <= 0;
            pwm_ls <= 0;
            cyc(5);
        end
        wr(12'h00c, 1);
        for (int c = 20; c > 0; c = c - 13)
        begin
            code <= c[7:0];
            node <= 0;
            pwm_hs <= 3'h1;
            wait_gate;
            lim = (1000 + c - 1) / c;
            k = 0;
            do
            begin
                @(posedge clk_sys);
                k++;
            end while (fault_n_oe_n !== 1'b0 && k < 400);
            chk(k >= lim && k <= lim + 1, 1);
            cyc(6);
            chk({power_enable, gate_hs}, 0);
            pwm_hs <= 0;
            node <= 3'h7;
            cyc(6);
            chk(fault_n_oe_n, 0);
            chk(irq, 1);
            apb(0, 12'h008, 0);
            chk(rd[0], 1);
            clr_req <= 1;
            cyc(4);
            clr_req <= 0;
            cyc(4);
            chk(fault_n_oe_n, 1);
            apb(1, 12'h008, 1);
            cyc(2);
            chk(irq, 0);
        end
        code <= 0;
        node <= 0;
        pwm_hs <= 3'h1;
        cyc(150);
        chk({fault_n_oe_n, gate_hs[0]}, 2'h3);
        apb(0, 12'h004, 0);
        chk(rd[5], 1);
        pwm_hs <= 0;
        node <= 3'h7;
        code <= 8'h14;
        for (int s = 0; s < 2; s++)
        begin
            uv_ls <= (s == 0);
            uv_cp <= (s == 1);
            cyc(6);
            chk(fault_n_oe_n, 0);
            clr_req <= 1;
            cyc(6);
            chk(fault_n_oe_n, 0);
            uv_ls <= 0;
            uv_cp <= 0;
            cyc(6);
            chk(fault_n_oe_n, 1);
            clr_req <= 0;
            apb(0, 12'h008, 0);
            chk(rd[1 + s], 1);
            apb(1, 12'h008, 7);
        end
        complete_run;
    end
endmodule
